/* verilog/dmr_map.vh */
// Constants for the DRAM mode register block: command codes,
// field positions, encodings and timing counts.
// Assumes a 15-bit mode word on the address bus and a 3-bit bank address.
`ifndef DMR_MAP_VH
`define DMR_MAP_VH

// Command encoding {cs_n, ras_n, cas_n, we_n}
`define DMR_CMD_LOAD_MODE   4'h0
`define DMR_CMD_READ        4'h5
`define DMR_CMD_WRITE       4'h4
`define DMR_BANK_MODE       3'h0
`define DMR_AP_BIT          10

// Mode word layout
`define DMR_WORD_W          15
`define DMR_BL_LSB          0
`define DMR_BL_MSB          2
`define DMR_BT_BIT          3
`define DMR_CL_LSB          4
`define DMR_CL_MSB          6
`define DMR_TM_BIT          7
`define DMR_DLLR_BIT        8
`define DMR_WR_LSB          9
`define DMR_WR_MSB          11
`define DMR_PD_BIT          12

// Encodings
`define DMR_BL_CODE4        3'h2
`define DMR_BL_CODE8        3'h3
`define DMR_RESET_WORD      15'h0000

// Timing
`define DMR_DLL_LOCK_CYC    8'hC8
`define DMR_MRD_CYC         2'h2
`define DMR_FAST_EXIT_CYC   4'h2
`define DMR_SLOW_EXIT_CYC   4'h8

`endif

/* verilog/dmr_burst_order.v */
// Column address for each beat of a burst, from start, length and type.
// Assumes beat index is held stable by the caller.
`timescale 1ns/1ns
module dmr_burst_order
(
  // Burst setup
  input  wire       burstLen8,
  input  wire       interleaved,
  input  wire [2:0] startCol,
  input  wire [2:0] beatIdx,
  // Resulting low column bits
  output wire [2:0] beatCol
);

  wire [1:0] seqLow;
  wire [2:0] ilv;

  // Sequential low two bits wrap inside nibble
  assign seqLow = startCol[1:0] + beatIdx[1:0];
  // Interleaved order is a plain xor
  assign ilv = startCol ^ beatIdx;
  // Length four keeps bit 2 of start; length eight flips nibble on beat 4
  assign beatCol = interleaved ?
                   (burstLen8 ? ilv : {startCol[2], ilv[1:0]}) :
                   (burstLen8 ? {startCol[2] ^ beatIdx[2], seqLow} : {startCol[2], seqLow});

endmodule

/* verilog/dmr_mode_reg.v */
// Mode register of a DDR-style DRAM, loaded by the load-mode command.
// Assumes commands are sampled on clk from controller logic on the same clock.
//
// Notes on behaviour
// - Load-mode with bank bits 000 latches the address bus into the register.
// - Fields hold until the next load; array data is untouched.
// - Burst length field selects four or eight, for reads and writes.
// - Burst stays in aligned block; low bits give start; wraps.
// - Bit 3 selects sequential or interleaved order.
// - Length four: start plus beat mod four, or start xor beat.
// - Length eight: xor over three bits, or nibble-based sequential.
// - Test bit set: no field written, test mode entered.
// - DLL restart bit starts a reset, then clears itself.
// - Write with auto precharge precharges write-recovery clocks after last data.
// - Power-down bit zero: fast exit, DLL running.
// - Power-down bit one: slow exit, DLL may freeze.
// - Column read latency is a whole count 3 to 6; the code passes any field value 0 to 7 through unchecked.
// - Read data starts column read latency after the read edge.
// - Posted extra latency delays an early read internally.
// - Total read latency is posted plus column; write latency one less.
`timescale 1ns/1ns
`include "dmr_map.vh"
module dmr_mode_reg
(
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Command bus
  input  wire [3:0]  cmdCode,
  input  wire [2:0]  bankAddr,
  input  wire [14:0] addrBus,
  // Posted extra latency from the extended register
  input  wire [2:0]  posted_extra_latency,
  // Power-down requests
  input  wire        activePowerDown,
  // Mode state
  output reg  [14:0] operating_mode_config,
  output reg  [3:0]  burst_len,
  output reg  [2:0]  column_read_latency,
  output reg  [3:0]  total_read_latency,
  output reg  [3:0]  writeLatency,
  output reg         testModeActive,
  output reg         dllResetPulse,
  output reg         dllLocked,
  output reg         modeSetBusy,
  output reg         lowPowerSlowExit,
  output reg  [3:0]  powerDownExitCycles,
  // Burst engine
  output reg         readDataValid,
  output reg         writeBurstActive,
  output reg  [2:0]  burstColumn,
  output reg         autoPrechargeStart
);

  reg  [2:0]  wrRecov;
  reg  [2:0]  beat_r;
  reg  [2:0]  startCol_r;
  reg         inBurst_r;
  reg         isWrite_r;
  reg         autoPre_r;
  reg  [3:0]  latCnt_r;
  reg         latRun_r;
  reg  [3:0]  recCnt_r;
  reg         recRun_r;
  reg  [7:0]  dllCnt_r;
  reg  [1:0]  mrdCnt_r;
  wire [2:0]  beatCol;
  wire        loadHit;
  wire        burstLen8;
  wire        isRead;
  wire        isWrite;
  wire [2:0]  lastBeat;
  reg  [2:0]  clCycles;

  // Mode-register decode
  assign loadHit   = (cmdCode == `DMR_CMD_LOAD_MODE) && (bankAddr == `DMR_BANK_MODE);
  assign burstLen8 = (operating_mode_config[`DMR_BL_MSB:`DMR_BL_LSB] == `DMR_BL_CODE8);
  assign isRead    = (cmdCode == `DMR_CMD_READ);
  assign isWrite   = (cmdCode == `DMR_CMD_WRITE);
  assign lastBeat  = burstLen8 ? 3'h7 : 3'h3;

  // Column latency and recovery codes decoded to counts
  always @*
  begin
    clCycles = operating_mode_config[`DMR_CL_MSB:`DMR_CL_LSB];
    wrRecov  = operating_mode_config[`DMR_WR_MSB:`DMR_WR_LSB] + 3'h1;
  end

  // Mode register store, test guard, self-clearing restart bit
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      operating_mode_config <= `DMR_RESET_WORD;
      testModeActive        <= 1'b0;
      dllResetPulse         <= 1'b0;
    end
    else
    begin
      dllResetPulse <= 1'b0;
      if (loadHit)
      begin
        if (addrBus[`DMR_TM_BIT])
          testModeActive <= 1'b1;
        else
        begin
          testModeActive        <= 1'b0;
          operating_mode_config <= addrBus & ~(15'h0001 << `DMR_DLLR_BIT);
          dllResetPulse         <= addrBus[`DMR_DLLR_BIT];
        end
      end
    end
  end

  // Derived latency and power-down outputs
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      burst_len           <= 4'h4;
      column_read_latency <= 3'h0;
      total_read_latency  <= 4'h0;
      writeLatency        <= 4'h0;
      lowPowerSlowExit    <= 1'b0;
      powerDownExitCycles <= `DMR_FAST_EXIT_CYC;
    end
    else
    begin
      burst_len           <= burstLen8 ? 4'h8 : 4'h4;
      column_read_latency <= clCycles;
      total_read_latency  <= {1'b0, posted_extra_latency} + {1'b0, clCycles};
      writeLatency        <= {1'b0, posted_extra_latency} + {1'b0, clCycles} - 4'h1;
      lowPowerSlowExit    <= activePowerDown & operating_mode_config[`DMR_PD_BIT];
      powerDownExitCycles <= operating_mode_config[`DMR_PD_BIT] ?
                             `DMR_SLOW_EXIT_CYC : `DMR_FAST_EXIT_CYC;
    end
  end

  // DLL lock counter and mode-set delay tracker
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      dllCnt_r    <= 8'h00;
      dllLocked   <= 1'b0;
      mrdCnt_r    <= 2'h0;
      modeSetBusy <= 1'b0;
    end
    else
    begin
      if (dllResetPulse)
      begin
        dllCnt_r  <= `DMR_DLL_LOCK_CYC;
        dllLocked <= 1'b0;
      end
      else if (dllCnt_r != 8'h00)
        dllCnt_r <= dllCnt_r - 8'h01;
      else
        dllLocked <= 1'b1;
      if (loadHit)
        mrdCnt_r <= `DMR_MRD_CYC;
      else if (mrdCnt_r != 2'h0)
        mrdCnt_r <= mrdCnt_r - 2'h1;
      modeSetBusy <= loadHit || (mrdCnt_r > 2'h1);
    end
  end

  // Burst sequencer: latency wait, beats, write recovery
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      beat_r             <= 3'h0;
      startCol_r         <= 3'h0;
      inBurst_r          <= 1'b0;
      isWrite_r          <= 1'b0;
      autoPre_r          <= 1'b0;
      latCnt_r           <= 4'h0;
      latRun_r           <= 1'b0;
      recCnt_r           <= 4'h0;
      recRun_r           <= 1'b0;
      readDataValid      <= 1'b0;
      writeBurstActive   <= 1'b0;
      burstColumn        <= 3'h0;
      autoPrechargeStart <= 1'b0;
    end
    else
    begin
      autoPrechargeStart <= 1'b0;
      if ((isRead || isWrite) && !testModeActive && !latRun_r && !inBurst_r)
      begin
        latRun_r   <= 1'b1;
        isWrite_r  <= isWrite;
        autoPre_r  <= addrBus[`DMR_AP_BIT];
        startCol_r <= addrBus[2:0];
        // Posted plus column latency, less one for writes, less two for burst and flag stages
        latCnt_r   <= {1'b0, posted_extra_latency} + {1'b0, clCycles}
                      - (isWrite ? 4'h3 : 4'h2);
      end
      else if (latRun_r)
      begin
        if (latCnt_r == 4'h0)
        begin
          latRun_r  <= 1'b0;
          inBurst_r <= 1'b1;
          beat_r    <= 3'h0;
        end
        else
          latCnt_r <= latCnt_r - 4'h1;
      end
      else if (inBurst_r)
      begin
        if (beat_r == lastBeat)
        begin
          inBurst_r <= 1'b0;
          if (isWrite_r && autoPre_r)
          begin
            recRun_r <= 1'b1;
            recCnt_r <= {1'b0, wrRecov} - 4'h1;
          end
        end
        else
          beat_r <= beat_r + 3'h1;
      end
      if (recRun_r)
      begin
        if (recCnt_r == 4'h0)
        begin
          recRun_r           <= 1'b0;
          autoPrechargeStart <= 1'b1;
        end
        else
          recCnt_r <= recCnt_r - 4'h1;
      end
      readDataValid    <= inBurst_r && !isWrite_r;
      writeBurstActive <= inBurst_r && isWrite_r;
      burstColumn      <= beatCol;
    end
  end

  // Column ordering within a burst
  dmr_burst_order uOrder
  (
    .burstLen8   (burstLen8),
    .interleaved (operating_mode_config[`DMR_BT_BIT]),
    .startCol    (startCol_r),
    .beatIdx     (beat_r),
    .beatCol     (beatCol)
  );

endmodule

/* tb/dmr_ctrl_model.sv */
// Controller model: issues load, read and write commands on the bus.
// Assumes the device samples commands on the rising edge of clk.
`timescale 1ns/1ns
`include "dmr_map.vh"
module dmr_ctrl_model
(
  // Clock and command bus
  input  wire logic        clk,
  output logic      [3:0]  cmdCode,
  output logic      [2:0]  bankAddr,
  output logic      [14:0] addrBus
);
  // Idle bus at time zero
  initial
  begin
    cmdCode = 4'h7;
    bankAddr = 3'h7;
    addrBus = 15'h7FFF;
  end
  // One command for one edge, then idle with the bus flipped
  task issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
  begin
    cmdCode = c;
    bankAddr = b;
    addrBus = a;
    @(posedge clk);
    #1;
    cmdCode = 4'h7;
    bankAddr = ~b;
    addrBus = ~a;
  end
  endtask
  // Whole word each time, then set delay and any relock wait
  task load(input logic [14:0] w);
  begin
    issue(`DMR_CMD_LOAD_MODE, `DMR_BANK_MODE, w);
    repeat (`DMR_MRD_CYC + 1) @(posedge clk);
    if (w[8])
      repeat (200) @(posedge clk);
    #1;
  end
  endtask
endmodule

/* tb/dmr_mode_reg_props.sv */
// Checker for the mode register: load, hold, DLL restart, bursts.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`include "dmr_map.vh"
module dmr_mode_reg_props
(
  // Clock, reset and commands
  input wire logic        clk, sys_rst, activePowerDown,
  input wire logic [3:0]  cmdCode,
  input wire logic [2:0]  bankAddr, posted_extra_latency,
  input wire logic [14:0] addrBus, operating_mode_config,
  // Watched outputs
  input wire logic [3:0]  burst_len,
  input wire logic [2:0]  column_read_latency,
  input wire logic        testModeActive, dllResetPulse, dllLocked, modeSetBusy,
  input wire logic        lowPowerSlowExit, readDataValid, writeBurstActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Command decode
  wire ld = cmdCode == `DMR_CMD_LOAD_MODE && bankAddr == `DMR_BANK_MODE;
  wire rd = cmdCode == `DMR_CMD_READ && !readDataValid && !writeBurstActive && !testModeActive;
  a_load_takes_word: assert property (ld && !addrBus[7] |=> operating_mode_config == ($past(addrBus) & 15'h7EFF))
    else $error("mode word not latched");
  a_test_no_write: assert property (ld && addrBus[7] |=> $stable(operating_mode_config) && testModeActive)
    else $error("test load changed word");
  a_word_holds: assert property (!ld |=> $stable(operating_mode_config))
    else $error("mode word changed without load");
  a_len_code: assert property (ld && !addrBus[7] |-> ##2 burst_len == ($past(addrBus[0], 2) ? 4'h8 : 4'h4))
    else $error("burst length wrong");
  a_dll_pulse: assert property (ld && !addrBus[7] && addrBus[8] |=> dllResetPulse ##1 !dllResetPulse)
    else $error("dll restart pulse wrong");
  a_dll_relock: assert property (dllResetPulse |=> !dllLocked ##[199:202] dllLocked)
    else $error("dll relock timing wrong");
  a_mode_busy: assert property (ld |=> modeSetBusy [*2])
    else $error("set delay not flagged");
  a_slow_exit: assert property (activePowerDown && operating_mode_config[12] |=> lowPowerSlowExit)
    else $error("slow exit missing");
  a_fast_exit: assert property (!operating_mode_config[12] |=> !lowPowerSlowExit)
    else $error("slow exit while fast chosen");
  a_read_cl3: assert property (rd && column_read_latency == 3'h3 && posted_extra_latency == 3'h0 |-> ##3 !readDataValid ##1 readDataValid)
    else $error("read latency wrong");
  a_len_four: assert property ($rose(readDataValid) && burst_len == 4'h4 |-> readDataValid [*4] ##1 !readDataValid)
    else $error("four beat burst wrong");
  a_len_eight: assert property ($rose(readDataValid) && burst_len == 4'h8 |-> readDataValid [*8] ##1 !readDataValid)
    else $error("eight beat burst wrong");
  // Main scenarios reached
  c_test: cover property (ld && addrBus[7]);
  c_dll: cover property (dllResetPulse);
  c_len8: cover property ($rose(readDataValid) && burst_len == 4'h8);
  c_slow: cover property (lowPowerSlowExit);
endmodule
bind dmr_mode_reg dmr_mode_reg_props chk (.clk, .sys_rst, .activePowerDown, .cmdCode, .bankAddr,
  .posted_extra_latency, .addrBus, .operating_mode_config, .burst_len, .column_read_latency, .testModeActive,
  .dllResetPulse, .dllLocked, .modeSetBusy, .lowPowerSlowExit, .readDataValid, .writeBurstActive);

/* tb/tb_dmr_mode_reg.sv */
// Testbench for the mode register: table of loads and bursts, then edge cases.
// Assumes the controller model drives the command bus.
`timescale 1ns/1ns
`include "dmr_map.vh"
module tb_dmr_mode_reg;
  logic        clk = 1'b0, sys_rst = 1'b1, activePowerDown = 1'b0;
  logic [2:0]  posted_extra_latency = 3'h0, al, st;
  logic [14:0] w;
  logic [3:0]  lat;
  logic [31:0] exp;
  wire  [3:0]  cmdCode, burst_len, total_read_latency, writeLatency, powerDownExitCycles;
  wire  [2:0]  bankAddr, column_read_latency, burstColumn;
  wire  [14:0] addrBus, operating_mode_config;
  wire         testModeActive, dllResetPulse, dllLocked, modeSetBusy, lowPowerSlowExit;
  wire         readDataValid, writeBurstActive, autoPrechargeStart;
  int          error_cnt = 0, n_tests = 0, i, k;
  // Rows: mode word, posted latency, start column, expected beat columns
  logic [52:0] rows [0:4] = '{{15'h0232, 3'h0, 3'h5, 32'h5674_0000}, {15'h044A, 3'h0, 3'h3, 32'h3210_0000},
    {15'h0653, 3'h2, 3'h5, 32'h5674_1230}, {15'h086B, 3'h4, 3'h6, 32'h6745_2301},
    {15'h1A33, 3'h1, 3'h7, 32'h7456_3012}};
  always #20 clk = ~clk;
  dmr_mode_reg dut (.clk, .sys_rst, .cmdCode, .bankAddr, .addrBus, .posted_extra_latency, .activePowerDown,
    .operating_mode_config, .burst_len, .column_read_latency, .total_read_latency, .writeLatency, .testModeActive,
    .dllResetPulse, .dllLocked, .modeSetBusy, .lowPowerSlowExit, .powerDownExitCycles, .readDataValid,
    .writeBurstActive, .burstColumn, .autoPrechargeStart);
  dmr_ctrl_model ctrl (.clk, .cmdCode, .bankAddr, .addrBus);
  // Counted comparison
  task check(input logic ok, input string m);
  begin
    n_tests++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  end
  endtask
  // Verdict and end of run
  task test_done;
  begin
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // One settled step after the next edge
  task step;
  begin
    @(posedge clk);
    #1;
    k++;
  end
  endtask
  // Issue a read or write, then follow its beats and any precharge
  task burst(input logic wr, input logic [3:0] l, input logic [3:0] bl, input logic ap, input logic [3:0] rec);
    int n;
  begin
    ctrl.issue(wr ? `DMR_CMD_WRITE : `DMR_CMD_READ, 3'h1, {4'h0, ap, 7'h0, st});
    k = 0;
    while ((wr ? writeBurstActive : readDataValid) !== 1'b1 && k < 30)
      step;
    check(k == l, "burst start");
    if (k >= 30)
      test_done;
    for (n = 0; n < bl; n++)
    begin
      check((wr ? writeBurstActive : readDataValid) === 1'b1 && burstColumn === exp[30 - 4 * n -: 3], "beat");
      step;
    end
    check((wr ? writeBurstActive : readDataValid) === 1'b0, "burst too long");
    k = 1;
    while (ap && autoPrechargeStart !== 1'b1 && k < 20)
      step;
    check(!ap || k == rec, "precharge delay");
  end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check(operating_mode_config === 15'h0000 && burst_len === 4'h4, "reset word");
    check(powerDownExitCycles === `DMR_FAST_EXIT_CYC, "reset exit count");
    // Legal codes only; each row loads, reads, then writes
    for (i = 0; i < 5; i++)
    begin
      {w, al, st, exp} = rows[i];
      posted_extra_latency = al;
      ctrl.load(w);
      lat = al + w[6:4];
      check(operating_mode_config === w && burst_len === (w[0] ? 4'h8 : 4'h4), "mode word");
      check(total_read_latency === lat && writeLatency === lat - 4'h1, "latency");
      burst(1'b0, lat, w[0] ? 4'h8 : 4'h4, 1'b0, 4'h0);
      burst(1'b1, lat - 4'h1, w[0] ? 4'h8 : 4'h4, 1'b0, 4'h0);
    end
    // Slow exit with bit set, then fast exit after reload with DLL restart
    activePowerDown = 1'b1;
    repeat (2) step;
    check(lowPowerSlowExit === 1'b1 && powerDownExitCycles === `DMR_SLOW_EXIT_CYC, "slow exit");
    posted_extra_latency = 3'h0;
    ctrl.load(15'h0B32);
    check(lowPowerSlowExit === 1'b0 && powerDownExitCycles === `DMR_FAST_EXIT_CYC, "fast exit");
    check(operating_mode_config === 15'h0A32 && dllLocked === 1'b1, "restart bit clears");
    activePowerDown = 1'b0;
    st = 3'h2;
    exp = 32'h2301_0000;
    burst(1'b1, 4'h2, 4'h4, 1'b1, 4'h6);
    // Test mode keeps the word and refuses reads
    ctrl.load(15'h02F3);
    check(operating_mode_config === 15'h0A32 && testModeActive === 1'b1, "test mode");
    ctrl.issue(`DMR_CMD_READ, 3'h1, 15'h0000);
    k = 0;
    repeat (10)
    begin
      @(posedge clk);
      #1;
      if (readDataValid !== 1'b0)
        k++;
    end
    check(k == 0, "read in test mode");
    ctrl.load(15'h0232);
    check(testModeActive === 1'b0 && operating_mode_config === 15'h0232, "leave test mode");
    test_done;
  end
endmodule
